// ---- inc/clock_ctrl_defs.vh ----
// constants for the converter clock source and delay loop control block
`ifndef CLOCK_CTRL_DEFS_VH
`define CLOCK_CTRL_DEFS_VH

`define ADDR_W              8
`define DATA_W              8

`define OFS_SOFT_RESET      8'h00
`define OFS_LOOP_CTRL       8'h52
`define OFS_ORIGIN_CTRL     8'h53
`define OFS_PHASE_CTRL      8'h64
`define OFS_PLL_CLK_CTRL    8'h6D
`define OFS_CLOCK_STATUS    8'h7E

// delay loop control fields
`define LOOP_EN_BIT         0
`define DUTY_BIT            1
`define LOOP_OUTCLK_BIT     2
`define LOOP_PHASE_LSB      3
`define LOOP_PHASE_MSB      5
`define LOOP_RESET_BIT      6
// clock origin field
`define ORIGIN_BIT          0
// output clock phase fields
`define PHASE_EN_BIT        0
`define DEC_PHASE_LSB       1
`define DEC_PHASE_MSB       3
// pll clock gate field
`define PLL_CLK_EN_BIT      0
// soft reset command field
`define SOFT_RESET_BIT      0
// status field: writing 1 clears the sticky loop reset advice
`define ADVISED_BIT         5

`define LOOP_CTRL_RESET     8'h40
`define ORIGIN_CTRL_RESET   8'h00
`define PHASE_CTRL_RESET    8'h00
`define PLL_CLK_CTRL_RESET  8'h00

// core clock source codes
`define CORE_DIRECT         2'h0
`define CORE_LOOP           2'h1
`define CORE_PLL            2'h2
// output data clock source codes
`define OUT_INPUT_BUFFER    2'h0
`define OUT_LOOP            2'h1
`define OUT_DECIMATION      2'h2
`define OUT_PLL             2'h3

`define CLK_PERIOD_NS       10
`define LOOP_RESET_NS       160
`define LOOP_RESET_CYCLES   ((`LOOP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOOP_CNT_W          5

`endif

// ---- rtl/dll_reset_ctrl.v ----
// sequencer that holds the delay loop in reset after a soft reset command
`timescale 1ns/100ps
`include "clock_ctrl_defs.vh"

module dll_reset_ctrl (
  input  wire clock,
  input  wire rst_b,
  input  wire start,
  output reg  busy,
  output reg  done
);

  localparam IDLE = 1'b0;
  localparam HOLD = 1'b1;
  localparam integer           LAST_INT = `LOOP_RESET_CYCLES - 1;
  localparam [`LOOP_CNT_W-1:0] LAST     = LAST_INT[`LOOP_CNT_W-1:0];

  reg                   state;
  reg [`LOOP_CNT_W-1:0] count;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= IDLE;
      count <= {`LOOP_CNT_W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          if (start) begin
            state <= HOLD;
            count <= {`LOOP_CNT_W{1'b0}};
            busy  <= 1'b1;
          end
        end
        HOLD: begin
          if (count == LAST) begin
            state <= IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end else begin
            count <= count + 1'b1;
          end
        end
        default: begin
          state <= IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- rtl/clock_route_decode.v ----
// combinational decode of the control bits into clock routing selects
`timescale 1ns/100ps
`include "clock_ctrl_defs.vh"

module clock_route_decode (
  input  wire       origin_pll,
  input  wire       loop_enable,
  input  wire       loop_in_reset,
  input  wire       duty_correction,
  input  wire       delay_loop_outclk_enable,
  input  wire       outclk_phase_shift_enable,
  input  wire [2:0] outclk_phase_via_loop,
  input  wire [2:0] outclk_phase_in_decimation,
  input  wire       decimation_active,
  input  wire       pll_clk_enable,
  output reg  [1:0] core_source,
  output reg        core_clock_gate,
  output reg        duty_active,
  output reg  [1:0] outclk_source,
  output reg        outclk_phase_active,
  output reg  [2:0] outclk_phase
);

  // the loop carries the core clock only with the external origin selected
  function loop_path;
    input pll_sel;
    input loop_en;
    begin
      loop_path = !pll_sel && loop_en;
    end
  endfunction

  always @* begin
    core_source         = `CORE_DIRECT;
    core_clock_gate     = 1'b1;
    duty_active         = 1'b0;
    outclk_source       = `OUT_INPUT_BUFFER;
    outclk_phase_active = 1'b0;
    outclk_phase        = 3'h0;
    if (origin_pll) begin
      core_source     = `CORE_PLL;
      core_clock_gate = pll_clk_enable;
    end else if (loop_path(origin_pll, loop_enable)) begin
      core_source     = `CORE_LOOP;
      core_clock_gate = !loop_in_reset;
      duty_active     = duty_correction;
    end
    if (decimation_active) begin
      outclk_source = `OUT_DECIMATION;
      if (outclk_phase_shift_enable) begin
        outclk_phase_active = 1'b1;
        outclk_phase        = outclk_phase_in_decimation;
      end
    end else if (origin_pll) begin
      outclk_source = `OUT_PLL;
    end else if (loop_path(origin_pll, loop_enable) && delay_loop_outclk_enable) begin
      outclk_source = `OUT_LOOP;
      if (outclk_phase_shift_enable) begin
        outclk_phase_active = 1'b1;
        outclk_phase        = outclk_phase_via_loop;
      end
    end else begin
      outclk_source = `OUT_INPUT_BUFFER;
    end
  end

endmodule

// ---- rtl/clock_select_ctrl.v ----
// clock source selection, delay loop control and output clock routing
`timescale 1ns/100ps
`include "clock_ctrl_defs.vh"

module clock_select_ctrl (
  input  wire              clock,
  input  wire              rst_b,
  input  wire [`ADDR_W-1:0] addr,
  input  wire [`DATA_W-1:0] wr_data,
  input  wire              wr_en,
  input  wire              rd_en,
  output reg  [`DATA_W-1:0] rd_data,
  input  wire              decimation_active,
  output reg  [1:0]        core_source,
  output reg               core_clock_gate,
  output reg               loop_active,
  output reg               loop_reset,
  output reg               duty_active,
  output reg  [1:0]        outclk_source,
  output reg               outclk_phase_active,
  output reg  [2:0]        outclk_phase,
  output reg               pll_clock_gate
);

  // control registers
  reg [`DATA_W-1:0] delay_loop_control;
  reg [`DATA_W-1:0] clock_origin_control;
  reg [`DATA_W-1:0] output_clock_phase_control;
  reg [`DATA_W-1:0] pll_clock_control;

  // sticky hint that the clock setup changed while the loop was running
  reg               reset_advised;

  wire wr_loop   = wr_en && (addr == `OFS_LOOP_CTRL);
  wire wr_origin = wr_en && (addr == `OFS_ORIGIN_CTRL);
  wire wr_phase  = wr_en && (addr == `OFS_PHASE_CTRL);
  wire wr_pll    = wr_en && (addr == `OFS_PLL_CLK_CTRL);
  wire wr_soft   = wr_en && (addr == `OFS_SOFT_RESET);
  wire wr_status = wr_en && (addr == `OFS_CLOCK_STATUS);

  wire loop_enable              = delay_loop_control[`LOOP_EN_BIT];
  wire duty_correction          = delay_loop_control[`DUTY_BIT];
  wire delay_loop_outclk_enable = delay_loop_control[`LOOP_OUTCLK_BIT];
  wire [2:0] outclk_phase_via_loop =
    delay_loop_control[`LOOP_PHASE_MSB:`LOOP_PHASE_LSB];
  wire loop_reset_bit           = delay_loop_control[`LOOP_RESET_BIT];
  wire origin_pll               = clock_origin_control[`ORIGIN_BIT];
  wire outclk_phase_shift_enable = output_clock_phase_control[`PHASE_EN_BIT];
  wire [2:0] outclk_phase_in_decimation =
    output_clock_phase_control[`DEC_PHASE_MSB:`DEC_PHASE_LSB];
  wire pll_clk_enable           = pll_clock_control[`PLL_CLK_EN_BIT];

  // soft reset only sequences the loop when the loop is enabled
  wire soft_start = wr_soft && wr_data[`SOFT_RESET_BIT] && loop_enable;

  wire seq_busy;
  wire seq_done;

  dll_reset_ctrl u_reset_seq (
    .clock (clock),
    .rst_b (rst_b),
    .start (soft_start),
    .busy  (seq_busy),
    .done  (seq_done)
  );

  wire       loop_in_reset = loop_reset_bit || seq_busy || soft_start;
  wire [1:0] next_core_source;
  wire       next_core_gate;
  wire       next_duty;
  wire [1:0] next_out_source;
  wire       next_phase_active;
  wire [2:0] next_phase;

  clock_route_decode u_decode (
    .origin_pll                 (origin_pll),
    .loop_enable                (loop_enable),
    .loop_in_reset              (loop_in_reset),
    .duty_correction            (duty_correction),
    .delay_loop_outclk_enable   (delay_loop_outclk_enable),
    .outclk_phase_shift_enable  (outclk_phase_shift_enable),
    .outclk_phase_via_loop      (outclk_phase_via_loop),
    .outclk_phase_in_decimation (outclk_phase_in_decimation),
    .decimation_active          (decimation_active),
    .pll_clk_enable             (pll_clk_enable),
    .core_source                (next_core_source),
    .core_clock_gate            (next_core_gate),
    .duty_active                (next_duty),
    .outclk_source              (next_out_source),
    .outclk_phase_active        (next_phase_active),
    .outclk_phase               (next_phase)
  );

  // a change of clock origin or loop enable while the loop runs calls for a
  // software loop reset; the block only flags it and does not act on its own
  wire setup_change = loop_enable && !loop_in_reset &&
                      ((wr_origin && (wr_data[`ORIGIN_BIT] != origin_pll)) ||
                       (wr_loop && !wr_data[`LOOP_EN_BIT]));

  wire [`DATA_W-1:0] status_word = {2'h0,
                                    reset_advised,
                                    seq_busy,
                                    loop_in_reset,
                                    core_clock_gate,
                                    core_source};

  // control register writes
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      delay_loop_control         <= `LOOP_CTRL_RESET;
      clock_origin_control       <= `ORIGIN_CTRL_RESET;
      output_clock_phase_control <= `PHASE_CTRL_RESET;
      pll_clock_control          <= `PLL_CLK_CTRL_RESET;
    end else begin
      if (wr_loop) begin
        delay_loop_control <= {1'b0, wr_data[`DATA_W-2:0]};
      end else if (soft_start) begin
        // the hold shows in the reset bit until the sequence clears it
        delay_loop_control[`LOOP_RESET_BIT] <= 1'b1;
      end else if (seq_done) begin
        // auto clear after the soft reset hold ends
        delay_loop_control[`LOOP_RESET_BIT] <= 1'b0;
      end
      if (wr_origin) begin
        clock_origin_control <= {7'h00, wr_data[`ORIGIN_BIT]};
      end
      if (wr_phase) begin
        output_clock_phase_control <= {4'h0, wr_data[`DEC_PHASE_MSB:0]};
      end
      if (wr_pll) begin
        pll_clock_control <= {7'h00, wr_data[`PLL_CLK_EN_BIT]};
      end
    end
  end

  // software may still set the reset bit during a sequence; a write wins over the
  // automatic clear only in the seq_done cycle, an earlier write is cleared when the hold ends

  // sticky flag: a new event wins over a software clear in the same cycle
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_advised <= 1'b0;
    end else if (setup_change) begin
      reset_advised <= 1'b1;
    end else if (wr_status && wr_data[`ADVISED_BIT]) begin
      reset_advised <= 1'b0;
    end
  end

  // read port: data one cycle after the strobe, zero for unmapped offsets
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= {`DATA_W{1'b0}};
    end else if (rd_en) begin
      case (addr)
        `OFS_LOOP_CTRL:    rd_data <= delay_loop_control;
        `OFS_ORIGIN_CTRL:  rd_data <= clock_origin_control;
        `OFS_PHASE_CTRL:   rd_data <= output_clock_phase_control;
        `OFS_PLL_CLK_CTRL: rd_data <= pll_clock_control;
        `OFS_CLOCK_STATUS: rd_data <= status_word;
        default:           rd_data <= {`DATA_W{1'b0}};
      endcase
    end else begin
      rd_data <= {`DATA_W{1'b0}};
    end
  end

  // routing outputs are registered so the clock muxes see glitch-free selects
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_source         <= `CORE_DIRECT;
      core_clock_gate     <= 1'b1;
      loop_active         <= 1'b0;
      loop_reset          <= 1'b1;
      duty_active         <= 1'b0;
      outclk_source       <= `OUT_INPUT_BUFFER;
      outclk_phase_active <= 1'b0;
      outclk_phase        <= 3'h0;
      pll_clock_gate      <= 1'b0;
    end else begin
      core_source         <= next_core_source;
      core_clock_gate     <= next_core_gate;
      loop_active         <= loop_enable;
      loop_reset          <= loop_in_reset;
      duty_active         <= next_duty && !loop_in_reset;
      outclk_source       <= next_out_source;
      outclk_phase_active <= next_phase_active;
      outclk_phase        <= next_phase;
      pll_clock_gate      <= origin_pll && pll_clk_enable;
    end
  end

endmodule

// ---- test/clk_ctrl_asserts.sv ----
// concurrent checks on the clock select block ports
`timescale 1ns/100ps
module clk_ctrl_asserts (
  input wire       clock,
  input wire       rst_b,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rd_data,
  input wire       decimation_active,
  input wire [1:0] core_source,
  input wire       core_clock_gate,
  input wire       loop_active,
  input wire       loop_reset,
  input wire       duty_active,
  input wire [1:0] outclk_source,
  input wire       outclk_phase_active,
  input wire [2:0] outclk_phase,
  input wire       pll_clock_gate
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_loop_enable_follows:
    assert property (wr_en && addr == 8'h52 |-> ##2 loop_active == $past(wr_data[0], 2))
    else $error("loop enable output does not follow the written bit");
  a_direct_gate_open:
    assert property (core_source == 2'h0 |-> core_clock_gate)
    else $error("direct clock gated off");
  a_loop_source_enabled:
    assert property (core_source == 2'h1 |-> loop_active)
    else $error("loop source chosen with loop off");
  a_pll_gate_tied:
    assert property (core_source == 2'h2 |-> core_clock_gate == pll_clock_gate)
    else $error("pll core gate differs from pll clock enable");
  a_pll_gate_mode:
    assert property (pll_clock_gate |-> core_source == 2'h2)
    else $error("pll clock passed outside pll mode");
  a_duty_scope:
    assert property (duty_active |-> core_source == 2'h1 && loop_active && !loop_reset)
    else $error("duty correction outside the running loop");
  a_outclk_loop_needs:
    assert property (outclk_source == 2'h1 |-> loop_active)
    else $error("output clock from an idle loop");
  a_phase_path_only:
    assert property (outclk_phase_active |-> outclk_source == 2'h2 || outclk_source == 2'h1)
    else $error("phase delay active outside loop or decimation path");
  a_soft_hold_run:
    assert property (wr_en && addr == 8'h00 && wr_data[0] && loop_active |=> loop_reset [*8])
    else $error("soft reset did not hold the loop");
  a_unmapped_zero:
    assert property (rd_en && addr == 8'h10 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind clock_select_ctrl clk_ctrl_asserts i_chk (
  .clock(clock), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .decimation_active(decimation_active),
  .core_source(core_source), .core_clock_gate(core_clock_gate),
  .loop_active(loop_active), .loop_reset(loop_reset), .duty_active(duty_active),
  .outclk_source(outclk_source), .outclk_phase_active(outclk_phase_active),
  .outclk_phase(outclk_phase), .pll_clock_gate(pll_clock_gate));

// ---- test/clk_host.sv ----
// host software model driving the register port
`timescale 1ns/100ps
module clk_host (
  input  wire       clock,
  input  wire [7:0] rd_data,
  output reg  [7:0] addr,
  output reg  [7:0] wr_data,
  output reg        wr_en,
  output reg        rd_en
);
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// ---- test/clock_select_ctrl_tb_top.sv ----
// testbench for the clock select block
`timescale 1ns/100ps
module clock_select_ctrl_tb_top;
  reg        clock;
  reg        rst_b;
  reg        decimation_active;
  wire [7:0] addr, wr_data, rd_data;
  wire       wr_en, rd_en, core_clock_gate, loop_active, loop_reset, duty_active;
  wire       outclk_phase_active, pll_clock_gate;
  wire [1:0] core_source, outclk_source;
  wire [2:0] outclk_phase;
  integer    bad_count, n_tests, cycles;
  reg  [7:0] rv;
  clock_select_ctrl i_clock_select_ctrl (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .decimation_active(decimation_active),
    .core_source(core_source), .core_clock_gate(core_clock_gate),
    .loop_active(loop_active), .loop_reset(loop_reset), .duty_active(duty_active),
    .outclk_source(outclk_source), .outclk_phase_active(outclk_phase_active),
    .outclk_phase(outclk_phase), .pll_clock_gate(pll_clock_gate));
  clk_host i_host (
    .clock(clock), .rd_data(rd_data), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en));
  // 100 MHz lies inside both the pll reference and sampling ranges
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs follow a write two edges after its strobe
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task t_reset;
    chk(core_source, 8'h00);
    chk(core_clock_gate, 8'h01);
    chk(loop_reset, 8'h01);
    chk(loop_active, 8'h00);
    chk(outclk_source, 8'h00);
    chk(pll_clock_gate, 8'h00);
    i_host.rd(8'h52, rv);
    chk(rv, 8'h40);
    i_host.rd(8'h53, rv);
    chk(rv, 8'h00);
    i_host.rd(8'h64, rv);
    chk(rv, 8'h00);
    i_host.rd(8'h10, rv);
    chk(rv, 8'h00);
  endtask
  // duty correction only to exercise it, a clean clock needs none
  task t_loop;
    // bit 7 is reserved and must read back as zero
    i_host.wr(8'h52, 8'hAF);
    i_host.wr(8'h64, 8'h01);
    settle;
    chk(core_source, 8'h01);
    chk(loop_active, 8'h01);
    chk(loop_reset, 8'h00);
    chk(duty_active, 8'h01);
    chk(outclk_source, 8'h01);
    chk(outclk_phase_active, 8'h01);
    chk(outclk_phase, 8'h05);
    i_host.rd(8'h52, rv);
    chk(rv, 8'h2F);
  endtask
  task t_dec;
    @(posedge clock) decimation_active <= 1'b1;
    i_host.wr(8'h64, 8'h07);
    settle;
    chk(outclk_source, 8'h02);
    chk(outclk_phase, 8'h03);
    @(posedge clock) decimation_active <= 1'b0;
  endtask
  task t_soft;
    i_host.wr(8'h00, 8'h01);
    i_host.rd(8'h52, rv);
    chk(rv & 8'h40, 8'h40);
    chk(loop_reset, 8'h01);
    repeat (25) @(posedge clock);
    #1;
    chk(loop_reset, 8'h00);
    i_host.rd(8'h52, rv);
    chk(rv, 8'h2F);
    i_host.wr(8'h52, 8'h00);
    i_host.wr(8'h00, 8'h01);
    settle;
    chk(loop_reset, 8'h00);
    chk(loop_active, 8'h00);
    chk(duty_active, 8'h00);
    chk(outclk_source, 8'h00);
    i_host.rd(8'h7E, rv);
    chk(rv, 8'h24);
    i_host.wr(8'h7E, 8'h20);
    i_host.rd(8'h7E, rv);
    chk(rv, 8'h04);
  endtask
  task t_pll;
    i_host.wr(8'h52, 8'h47);
    i_host.wr(8'h53, 8'h01);
    settle;
    chk(loop_reset, 8'h01);
    chk(core_source, 8'h02);
    chk(core_clock_gate, 8'h00);
    chk(pll_clock_gate, 8'h00);
    chk(duty_active, 8'h00);
    chk(outclk_source, 8'h03);
    i_host.wr(8'h6D, 8'h01);
    settle;
    chk(pll_clock_gate, 8'h01);
    chk(core_clock_gate, 8'h01);
    i_host.rd(8'h53, rv);
    chk(rv, 8'h01);
  endtask
  initial begin
    rst_b = 1'b0;
    decimation_active = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    t_reset;
    t_loop;
    t_dec;
    t_soft;
    t_pll;
    report_and_stop;
  end
endmodule
